//--- rtl/timer_cmp_consts.svh
// Purpose: Offsets, field positions and reset values of the compare block
// Assumes: APB byte addresses, one register per aligned word
// Notes:   Definitions only
`ifndef TIMER_CMP_CONSTS_SVH
`define TIMER_CMP_CONSTS_SVH

`define OFS_CTRL_A      8'h00
`define OFS_CTRL_B      8'h04
`define OFS_FLAGS       8'h08
`define OFS_CMP1_HI     8'h0c
`define OFS_CMP1_LO     8'h10
`define OFS_CMP2_HI     8'h14
`define OFS_CMP2_LO     8'h18

`define CMP_RESET       16'h8000
`define CNT_RELOAD_VAL  16'hfffc
`define CAP1_TRIG_VAL   16'hfffd

`define CLKDIV_2        2'h2
`define CMP_LAG         16'h0001

// Control register A fields
`define A_CAP_IRQ_EN    7
`define A_CMP_IRQ_EN    6
`define A_FORCE2        4
`define A_FORCE1        3
`define A_LVL_DURING    2
`define A_TRIG_EDGE     1
`define A_LVL_AFTER     0

// Control register B fields
`define B_PIN_EN1       7
`define B_PIN_EN2       6
`define B_PULSE_SEL     5
`define B_PWM_SEL       4
`define B_DIV_HI        3
`define B_DIV_LO        2

// Flags register fields
`define F_CAP1          7
`define F_CMP1          6
`define F_CAP2          4
`define F_CMP2          3

`endif

//--- rtl/timer_cmp_pkg.sv
// Purpose: Types of the compare block
// Assumes: Constants come from the header
// Notes:   State travels as one packed struct
package timer_cmp_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_PULSE  = 3'b010,
    MODE_PWM    = 3'b100
  } mode_t;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] act1;
    logic [15:0] act2;
    logic [1:0]  inhibit;
    logic [1:0]  flag;
    logic [1:0]  arm;
    logic [1:0]  pin;
    logic        trig_prev;
    logic        reload;
    logic        cap1_set;
    logic [31:0] prdata;
  } state_t;

endpackage

//--- rtl/timer_compare_pulse_pwm.sv
// Purpose: Output compare, one-pulse and PWM section of a 16-bit timer
// Assumes: Counter, prescaler and capture logic sit outside; APB access
// Notes:   cnt_tick marks the cycle in which cnt_value holds a new count
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_consts.svh"

module timer_compare_pulse_pwm (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] cnt_value,
  input  wire logic        cnt_tick,
  output logic             cnt_reload,
  output logic [1:0]       clk_div_sel,
  input  wire logic        trig_in1,
  input  wire logic        cap1_flag,
  input  wire logic        cap2_flag,
  output logic             cap1_capture_en,
  output logic             cap1_set,
  output logic [15:0]      cap1_value,
  input  wire logic        irq_mask,
  output logic             timer_irq,
  output logic             wave_out1,
  output logic             wave_out1_en,
  output logic             wave_out2,
  output logic             wave_out2_en
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  timer_cmp_pkg::state_t s_q;
  timer_cmp_pkg::state_t s_d;
  timer_cmp_pkg::mode_t  mode;

  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr;
  logic        rd;
  logic [1:0]  lo_acc;
  logic [1:0]  hi_wr;
  logic [15:0] tgt1;
  logic [15:0] tgt2;
  logic        m1;
  logic        m2;
  logic        trig_edge;
  logic        div2;
  logic [7:0]  flags;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == `OFS_CTRL_A) | (paddr == `OFS_CTRL_B) |
                  (paddr == `OFS_FLAGS) | (paddr == `OFS_CMP1_HI) |
                  (paddr == `OFS_CMP1_LO) | (paddr == `OFS_CMP2_HI) |
                  (paddr == `OFS_CMP2_LO);
  assign wr     = access & pwrite & mapped;
  assign rd     = access & ~pwrite & mapped;
  assign lo_acc = {access & mapped & (paddr == `OFS_CMP2_LO),
                   access & mapped & (paddr == `OFS_CMP1_LO)};
  assign hi_wr  = {wr & (paddr == `OFS_CMP2_HI), wr & (paddr == `OFS_CMP1_HI)};

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = s_q.prdata;

  // ----------------------------------------------------------------
  // Mode and match detection
  // ----------------------------------------------------------------
  // PWM select wins
  // PWM takes priority
  always_comb begin
    if (s_q.ctrl_b[`B_PWM_SEL]) begin
      mode = timer_cmp_pkg::MODE_PWM;
    end else if (s_q.ctrl_b[`B_PULSE_SEL]) begin
      mode = timer_cmp_pkg::MODE_PULSE;
    end else begin
      mode = timer_cmp_pkg::MODE_NORMAL;
    end
  end

  assign div2 = (s_q.ctrl_b[`B_DIV_HI:`B_DIV_LO] == `CLKDIV_2);
  assign tgt1 = div2 ? s_q.act1 : s_q.act1 + `CMP_LAG;
  assign tgt2 = div2 ? s_q.act2 : s_q.act2 + `CMP_LAG;
  assign m1 = cnt_tick & (cnt_value == tgt1) & ~s_q.inhibit[0];
  assign m2 = cnt_tick & (cnt_value == tgt2) & ~s_q.inhibit[1];

  assign trig_edge = s_q.ctrl_a[`A_TRIG_EDGE] ? (trig_in1 & ~s_q.trig_prev)
                                              : (~trig_in1 & s_q.trig_prev);

  always_comb begin
    flags            = 8'h00;
    flags[`F_CAP1]   = cap1_flag;
    flags[`F_CMP1]   = s_q.flag[0];
    flags[`F_CAP2]   = cap2_flag;
    flags[`F_CMP2]   = s_q.flag[1];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.trig_prev = trig_in1;
    s_d.reload    = 1'b0;
    s_d.cap1_set  = 1'b0;

    // Register writes
    if (wr) begin
      case (paddr)
        `OFS_CTRL_A:  s_d.ctrl_a = pwdata[7:0];
        `OFS_CTRL_B:  s_d.ctrl_b = pwdata[7:0];
        `OFS_CMP1_HI: s_d.cmp1[15:8] = pwdata[7:0];
        `OFS_CMP1_LO: s_d.cmp1[7:0] = pwdata[7:0];
        `OFS_CMP2_HI: s_d.cmp2[15:8] = pwdata[7:0];
        `OFS_CMP2_LO: s_d.cmp2[7:0] = pwdata[7:0];
        default: ;
      endcase
    end

    // Read data captured in setup phase
    if (setup) begin
      case (paddr)
        `OFS_CTRL_A:  s_d.prdata = {24'h000000, s_q.ctrl_a};
        `OFS_CTRL_B:  s_d.prdata = {24'h000000, s_q.ctrl_b};
        `OFS_FLAGS:   s_d.prdata = {24'h000000, flags};
        `OFS_CMP1_HI: s_d.prdata = {24'h000000, s_q.cmp1[15:8]};
        `OFS_CMP1_LO: s_d.prdata = {24'h000000, s_q.cmp1[7:0]};
        `OFS_CMP2_HI: s_d.prdata = {24'h000000, s_q.cmp2[15:8]};
        `OFS_CMP2_LO: s_d.prdata = {24'h000000, s_q.cmp2[7:0]};
        default:      s_d.prdata = 32'h00000000;
      endcase
    end

    // high write inhibits, low write releases
    for (int i = 0; i < 2; i++) begin
      if (hi_wr[i]) begin
        s_d.inhibit[i] = 1'b1;
      end else if (lo_acc[i] & pwrite) begin
        s_d.inhibit[i] = 1'b0;
      end
      if (rd & (paddr == `OFS_FLAGS) & s_q.flag[i]) begin
        s_d.arm[i] = 1'b1;
      end else if (lo_acc[i]) begin
        s_d.arm[i] = 1'b0;
      end
      if (lo_acc[i] & s_q.arm[i]) begin
        s_d.flag[i] = 1'b0;
      end
    end

    // shadow copies follow at once outside PWM
    if (mode != timer_cmp_pkg::MODE_PWM) begin
      s_d.act1 = s_d.cmp1;
      s_d.act2 = s_d.cmp2;
    end

    case (mode)
      timer_cmp_pkg::MODE_NORMAL: begin
        // latch follows even if pin disabled
        if (m1) begin
          s_d.flag[0] = 1'b1;
          s_d.pin[0]  = s_q.ctrl_a[`A_LVL_AFTER];
        end
        if (m2) begin
          s_d.flag[1] = 1'b1;
          s_d.pin[1]  = s_q.ctrl_a[`A_LVL_DURING];
        end
        if (s_q.ctrl_a[`A_FORCE1]) begin
          s_d.pin[0] = s_q.ctrl_a[`A_LVL_AFTER];
        end
        if (s_q.ctrl_a[`A_FORCE2]) begin
          s_d.pin[1] = s_q.ctrl_a[`A_LVL_DURING];
        end
      end
      timer_cmp_pkg::MODE_PULSE: begin
        // pin two not driven by matches
        if (m2) begin
          s_d.flag[1] = 1'b1;
        end
        if (m1) begin
          s_d.pin[0] = s_q.ctrl_a[`A_LVL_AFTER];
        end
        if (trig_edge) begin
          s_d.pin[0]   = s_q.ctrl_a[`A_LVL_DURING];
          s_d.reload   = 1'b1;
          s_d.cap1_set = 1'b1;
        end
      end
      timer_cmp_pkg::MODE_PWM: begin
        if (m1) begin
          s_d.pin[0] = s_q.ctrl_a[`A_LVL_AFTER];
        end
        // new values applied at period end
        if (m2) begin
          s_d.pin[0]   = s_q.ctrl_a[`A_LVL_DURING];
          s_d.reload   = 1'b1;
          s_d.cap1_set = 1'b1;
          s_d.act1     = s_d.cmp1;
          s_d.act2     = s_d.cmp2;
        end
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // pin latches low in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.cmp1      <= `CMP_RESET;
      s_q.cmp2      <= `CMP_RESET;
      s_q.act1      <= `CMP_RESET;
      s_q.act2      <= `CMP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cnt_reload  = s_q.reload;
  assign cap1_set    = s_q.cap1_set;
  assign cap1_value  = `CAP1_TRIG_VAL;
  assign clk_div_sel = s_q.ctrl_b[`B_DIV_HI:`B_DIV_LO];
  // capture one only in normal mode
  assign cap1_capture_en = (mode == timer_cmp_pkg::MODE_NORMAL);

  assign wave_out1    = s_q.pin[0];
  assign wave_out1_en = s_q.ctrl_b[`B_PIN_EN1];
  assign wave_out2    = s_q.pin[1];
  assign wave_out2_en = s_q.ctrl_b[`B_PIN_EN2];

  assign timer_irq = ~irq_mask &
                     ((s_q.ctrl_a[`A_CMP_IRQ_EN] & (|s_q.flag)) |
                      (s_q.ctrl_a[`A_CAP_IRQ_EN] & (cap1_flag | cap2_flag)));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  match_sets_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (m1 && mode == timer_cmp_pkg::MODE_NORMAL) |=> s_q.flag[0])
    else $error("compare match did not set flag one");

  match_drives_pin_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (m2 && mode == timer_cmp_pkg::MODE_NORMAL && !s_q.ctrl_a[`A_FORCE2])
    |=> wave_out2 == $past(s_q.ctrl_a[`A_LVL_DURING]))
    else $error("pin two did not take its level");

  irq_gating_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (irq_mask |-> !timer_irq) and
    ((s_q.flag[0] && s_q.ctrl_a[`A_CMP_IRQ_EN] && !irq_mask) |-> timer_irq))
    else $error("interrupt gating wrong");

  flag_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (lo_acc[0] && s_q.arm[0] && !m1) |=> !s_q.flag[0])
    else $error("flag one not cleared by low byte access");

  hi_write_inhibit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (hi_wr[0] || (s_q.inhibit[0] && !(lo_acc[0] && pwrite))) |=> (s_q.inhibit[0] && !m1))
    else $error("match during high byte inhibit");

  pulse_no_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode != timer_cmp_pkg::MODE_NORMAL) |=> !$rose(s_q.flag[0]))
    else $error("flag one set outside normal mode");

  pulse_trigger_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == timer_cmp_pkg::MODE_PULSE && trig_edge)
    |=> cnt_reload && cap1_set && wave_out1 == $past(s_q.ctrl_a[`A_LVL_DURING]))
    else $error("trigger did not start a pulse");

  pwm_period_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == timer_cmp_pkg::MODE_PWM && m2) |=> cnt_reload ##1 !cnt_reload)
    else $error("period end did not reload counter once");

  pwm_no_flags_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == timer_cmp_pkg::MODE_PWM) |=> !$rose(s_q.flag[1]))
    else $error("compare flag two set in PWM mode");

  force_ignored_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode != timer_cmp_pkg::MODE_NORMAL && !m1 && !m2 && !trig_edge) |=> $stable(wave_out1))
    else $error("pin one moved without an event outside normal mode");

  force_copy_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == timer_cmp_pkg::MODE_NORMAL && s_q.ctrl_a[`A_FORCE1])
    |=> wave_out1 == $past(s_q.ctrl_a[`A_LVL_AFTER]))
    else $error("force did not copy level one");

  pulse_after_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == timer_cmp_pkg::MODE_PULSE && m1 && !trig_edge)
    |=> wave_out1 == $past(s_q.ctrl_a[`A_LVL_AFTER]))
    else $error("pulse did not end with after level");

  pulse_pin_two_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode != timer_cmp_pkg::MODE_NORMAL) |=> $stable(wave_out2))
    else $error("pin two changed outside normal mode");

  pwm_cap_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == timer_cmp_pkg::MODE_PWM && m2)
    |=> cap1_set && wave_out1 == $past(s_q.ctrl_a[`A_LVL_DURING]))
    else $error("period end did not set capture one");

endmodule

`default_nettype wire

//--- tb/pin_model.sv
// Purpose: Pins outside the compare block
// Assumes: Trigger driven synchronously to pclk
// Notes:   Released wave pins read the pull-up level
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic pclk,
  input  wire logic trig_level,
  input  wire logic wave_out1,
  input  wire logic wave_out1_en,
  input  wire logic wave_out2,
  input  wire logic wave_out2_en,
  output logic      trig_in1,
  output logic      pad1,
  output logic      pad2
);
  always @(posedge pclk) trig_in1 <= trig_level;
  assign pad1 = wave_out1_en ? wave_out1 : 1'b1;
  assign pad2 = wave_out2_en ? wave_out2 : 1'b1;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench of the compare block
// Assumes: Zero-wait APB slave
// Notes:   Reads are checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_consts.svh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] cnt_value = 0, cap1_value, v, w, v2;
  logic cnt_tick = 0, trig_level = 0, cap1_flag = 0, cap2_flag = 0, irq_mask = 0;
  logic pready, pslverr, cnt_reload, trig_in1, cap1_capture_en, cap1_set, timer_irq;
  logic wave_out1, wave_out1_en, wave_out2, wave_out2_en, pad1, pad2;
  logic [1:0] clk_div_sel;
  logic [32:0] exp_q[$];
  int err_count = 0, cmp_count = 0, cyc = 0;
  timer_compare_pulse_pwm i_timer_compare_pulse_pwm (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt_value(cnt_value),
    .cnt_tick(cnt_tick), .cnt_reload(cnt_reload), .clk_div_sel(clk_div_sel),
    .trig_in1(trig_in1), .cap1_flag(cap1_flag), .cap2_flag(cap2_flag),
    .cap1_capture_en(cap1_capture_en), .cap1_set(cap1_set), .cap1_value(cap1_value),
    .irq_mask(irq_mask), .timer_irq(timer_irq), .wave_out1(wave_out1),
    .wave_out1_en(wave_out1_en), .wave_out2(wave_out2), .wave_out2_en(wave_out2_en));
  pin_model i_pin_model (.pclk(pclk), .trig_level(trig_level), .wave_out1(wave_out1),
    .wave_out1_en(wave_out1_en), .wave_out2(wave_out2), .wave_out2_en(wave_out2_en),
    .trig_in1(trig_in1), .pad1(pad1), .pad2(pad2));
  initial begin
    forever #4 pclk = ~pclk;
  end
  // ---------------------------------
  // Helpers
  // ---------------------------------
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back({e[8], 24'h0, e[7:0]});
    apb(1'b0, a, 8'h00);
  endtask
  task automatic tick(input logic [15:0] c);
    @(posedge pclk);
    cnt_value <= c;
    cnt_tick <= 1;
    @(posedge pclk);
    cnt_tick <= 0;
    #1;
  endtask
  task automatic trig(input logic lvl);
    @(posedge pclk);
    trig_level <= lvl;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("read queue", 33'h1, 33'h0);
      else chk("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ---------------------------------
  // Tests
  // ---------------------------------
  initial begin
    void'($urandom(32'h6ad7c738));
    v = 16'h0100 + 16'($urandom % 4096);
    w = v + 16'h0200;
    v2 = v + 16'h0080;
    repeat (16) @(posedge pclk);
    #1 chk("wave_out1 reset", wave_out1, 1'b0);
    @(posedge pclk);
    presetn <= 1;
    rd(`OFS_CTRL_A, 9'h000);
    rd(`OFS_CMP1_HI, 9'h080);
    rd(`OFS_CMP1_LO, 9'h000);
    rd(`OFS_CMP2_HI, 9'h080);
    rd(8'h1c, 9'h100);
    $display("test reset done");
    apb(1, `OFS_CTRL_B, 8'h88);
    apb(1, `OFS_CTRL_A, 8'h45);
    apb(1, `OFS_CMP1_HI, v[15:8]);
    apb(1, `OFS_CMP1_LO, v[7:0]);
    tick(v);
    chk("wave_out1", wave_out1, 1'b1);
    chk("timer_irq", timer_irq, 1'b1);
    @(posedge pclk) irq_mask <= 1;
    @(posedge pclk) #1 chk("timer_irq masked", timer_irq, 1'b0);
    @(posedge pclk) irq_mask <= 0;
    rd(`OFS_FLAGS, 9'h040);
    apb(1, `OFS_CMP1_HI, v[15:8]);
    rd(`OFS_FLAGS, 9'h040);
    apb(1, `OFS_CMP1_LO, v[7:0]);
    rd(`OFS_FLAGS, 9'h000);
    apb(1, `OFS_CMP1_HI, v[15:8]);
    tick(v);
    rd(`OFS_FLAGS, 9'h000);
    apb(1, `OFS_CMP1_LO, v[7:0]);
    tick(v);
    rd(`OFS_FLAGS, 9'h040);
    rd(`OFS_FLAGS, 9'h040);
    apb(1, `OFS_CMP1_LO, v[7:0]);
    $display("test compare done");
    apb(1, `OFS_CTRL_B, 8'h84);
    chk("clk_div_sel", clk_div_sel, 2'h1);
    tick(v);
    rd(`OFS_FLAGS, 9'h000);
    tick(v + 16'h0001);
    rd(`OFS_FLAGS, 9'h040);
    apb(1, `OFS_CTRL_B, 8'h08);
    apb(1, `OFS_CMP2_HI, w[15:8]);
    apb(1, `OFS_CMP2_LO, w[7:0]);
    tick(w);
    chk("pad2", pad2, 1'b1);
    chk("wave_out2", wave_out2, 1'b1);
    chk("wave_out2_en", wave_out2_en, 1'b0);
    rd(`OFS_FLAGS, 9'h048);
    apb(1, `OFS_CTRL_B, 8'h88);
    apb(1, `OFS_CTRL_A, 8'h08);
    repeat (2) @(posedge pclk);
    #1 chk("wave_out1 forced", wave_out1, 1'b0);
    rd(`OFS_FLAGS, 9'h048);
    apb(1, `OFS_CMP1_LO, v[7:0]);
    apb(1, `OFS_CMP2_LO, w[7:0]);
    rd(`OFS_FLAGS, 9'h000);
    $display("test divider and force done");
    apb(1, `OFS_CTRL_A, 8'h8b);
    apb(1, `OFS_CTRL_B, 8'ha8);
    trig(1);
    chk("cnt_reload", cnt_reload, 1'b1);
    chk("cap1_set", cap1_set, 1'b1);
    chk("cap1_value", cap1_value, `CAP1_TRIG_VAL);
    chk("wave_out1 during", wave_out1, 1'b0);
    chk("cap1_capture_en", cap1_capture_en, 1'b0);
    @(posedge pclk) cap1_flag <= 1;
    @(posedge pclk) #1 chk("timer_irq cap", timer_irq, 1'b1);
    @(posedge pclk) cap1_flag <= 0;
    tick(v);
    chk("wave_out1 after", wave_out1, 1'b1);
    chk("pad1 after", pad1, 1'b1);
    tick(w);
    chk("pulse wave_out2", wave_out2, 1'b1);
    rd(`OFS_FLAGS, 9'h008);
    apb(1, `OFS_CMP2_LO, w[7:0]);
    $display("test pulse done");
    apb(1, `OFS_CTRL_A, 8'h86);
    apb(1, `OFS_CTRL_B, 8'hb8);
    tick(v);
    chk("pwm low", wave_out1, 1'b0);
    tick(w);
    chk("pwm high", wave_out1, 1'b1);
    chk("pwm reload", cnt_reload, 1'b1);
    chk("pwm cap1_set", cap1_set, 1'b1);
    trig(0);
    trig(1);
    chk("pwm trig reload", cnt_reload, 1'b0);
    rd(`OFS_FLAGS, 9'h000);
    apb(1, `OFS_CMP1_HI, v2[15:8]);
    apb(1, `OFS_CMP1_LO, v2[7:0]);
    tick(v2);
    chk("pwm shadow", wave_out1, 1'b1);
    tick(w);
    tick(v2);
    chk("pwm new value", wave_out1, 1'b0);
    $display("test pwm done");
    @(posedge pclk);
    report_and_stop();
  end
endmodule
`default_nettype wire
